// File: eep_pkg.sv
package eep_pkg;

    // Array and page geometry.
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 512;
    localparam int PAGE_W = 4;
    localparam int PAGE_DEPTH = 16;

    // Select byte fields.
    localparam int SEL_RW_BIT = 0;
    localparam int SEL_MSB_BIT = 1;
    localparam int SEL_LO_BIT = 2;
    localparam int SEL_HI_BIT = 3;
    localparam int SEL_ID_LSB = 4;
    localparam logic SEL_READ = 1'h1;

    // Positions inside a nine-clock frame, counted in rising clock edges.
    localparam logic [3:0] BIT_TENTH = 4'h1;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_FRAME_END = 4'h9;
    localparam logic [3:0] BIT_MSB_IDX = 4'h7;

    // Programming cycle timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS = 5_000_000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int PROG_CNT_W = 20;
    localparam logic [PROG_CNT_W-1:0] COPY_FIRST = 20'h0_0001;
    localparam logic [PROG_CNT_W-1:0] COPY_LAST = 20'h0_0010;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SEL = 3'h1,
        ST_ADDR = 3'h3,
        ST_WDATA = 3'h2,
        ST_RDATA = 3'h6,
        ST_PROG = 3'h7
    } eep_state_t;

    // Levels that enter the system clock domain through the synchronizer; the link bit enters directly.
    typedef struct packed {
        logic link_tog;
        logic strap_hi;
        logic strap_lo;
        logic wp;
        logic sda;
        logic scl;
    } eep_pins_t;

endpackage

// File: eep_sync.sv
`timescale 1ns/1ps
module eep_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule // eep_sync

// File: eep_ram.sv
`timescale 1ns/1ps
module eep_ram #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);

    logic [W-1:0] mem_ff [D];
    logic [W-1:0] rd_data_ff;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    // Registered read keeps the output stable for a whole clock cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;

endmodule // eep_ram

// File: eep_i2c_slave.sv
// How it works
// - Data falling while clock high is a start; ignored during programming.
// - Data rising while clock high is a stop; it ends the exchange.
// - Incoming data bits are captured on the rising clock edge.
// - After eight bits the receiver pulls data low during the ninth clock.
// - Select byte must match type identifier and both straps, else go standby.
// - Select bit one is the address top bit; last bit one means read.
// - Write select is acknowledged, then the address byte, then data bytes follow.
// - Programming starts only on a stop in the tenth slot after data.
// - After programming the counter points just past the last written byte.
// - During programming the data output is off and all traffic is ignored.
// - With protection high data bytes get no acknowledge and nothing is programmed.
// - With protection high select and address bytes are still acknowledged.
// - One page write takes up to sixteen bytes sharing the upper address bits.
// - The page offset advances per byte and wraps to zero within the page.
// - Select bytes sent while busy are not acknowledged; afterwards they are.
// - Reads behave the same whatever the protection input level.
// - A read byte without master acknowledge stops output and enters standby.
// - Write select and address, repeated start, read select gives a random read.
// - A read without address returns the current byte, then the counter increments.
// - An acknowledged read byte is followed by the next consecutive byte.
// - Sequential reads wrap from the last location to address zero.
// - A stop after an unacknowledged read byte leaves the device in standby.
`timescale 1ns/1ps
module eep_i2c_slave #(
    parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF,
    // Value is arbitrary.
    parameter logic [3:0] TYPE_ID = 4'h5
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Two-wire bus
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and protection
    input wire logic strap_addr_low,
    input wire logic strap_addr_high,
    input wire logic write_protect_in,
    // Status
    output logic busy
);

    logic [1:0] rst_pipe_ff;
    logic rst_sync_n;
    logic link_bit_ff;
    logic link_tog_ff;
    eep_pkg::eep_pins_t pins_raw;
    eep_pkg::eep_pins_t pins_s;
    eep_pkg::eep_pins_t pins_d_ff;
    eep_pkg::eep_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic ack_ff;
    logic sda_oe_ff;
    logic [eep_pkg::ADDR_W-1:0] addr_ff;
    logic [eep_pkg::PAGE_W-1:0] wr_off_ff;
    logic [eep_pkg::PAGE_W-1:0] last_off_ff;
    logic [eep_pkg::PAGE_DEPTH-1:0] mask_ff;
    logic [eep_pkg::PROG_CNT_W-1:0] prog_cnt_ff;
    logic rise_ev, fall_ev, start_ev, stop_ev;
    logic byte_done, ack_rise, ack_fall, frame_end;
    logic in_prog, prog_done, tenth_stop, sel_match, tx_start, buf_wr;
    logic [7:0] rx_byte;
    logic [7:0] mem_rdata;
    logic [7:0] buf_rdata;
    logic [eep_pkg::PAGE_W-1:0] copy_idx;
    logic mem_wr;
    logic [eep_pkg::ADDR_W-1:0] next_after_last;

    // Reset is released through two flops.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_ff <= 2'h0;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'h1};
        end
    end
    assign rst_sync_n = rst_pipe_ff[1];

    // Link domain: the bit is held for a whole clock period, so the toggle alone crosses.
    always_ff @(posedge scl_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            link_bit_ff <= 1'h0;
            link_tog_ff <= 1'h0;
        end else begin
            link_bit_ff <= sda_in;
            link_tog_ff <= ~link_tog_ff;
        end
    end

    always_comb begin
        pins_raw = '0;
        pins_raw.link_tog = link_tog_ff;
        pins_raw.strap_hi = strap_addr_high;
        pins_raw.strap_lo = strap_addr_low;
        pins_raw.wp = write_protect_in;
        pins_raw.sda = sda_in;
        pins_raw.scl = scl_clk;
    end

    eep_sync #(
        .W($bits(eep_pkg::eep_pins_t))
    ) u_sync (
        .clk(sys_clk),
        .rst_n(rst_sync_n),
        .d(pins_raw),
        .q(pins_s)
    );

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pins_d_ff <= '0;
        end else begin
            pins_d_ff <= pins_s;
        end
    end

    // Bus events.
    assign rise_ev = pins_s.link_tog ^ pins_d_ff.link_tog;
    assign fall_ev = pins_d_ff.scl & ~pins_s.scl;
    assign start_ev = pins_s.scl & pins_d_ff.scl & pins_d_ff.sda & ~pins_s.sda;
    assign stop_ev = pins_s.scl & pins_d_ff.scl & ~pins_d_ff.sda & pins_s.sda;

    assign rx_byte = {shift_ff[6:0], link_bit_ff};
    assign byte_done = rise_ev && (bit_cnt_ff == eep_pkg::BIT_LAST_DATA);
    assign ack_rise = rise_ev && (bit_cnt_ff == eep_pkg::BIT_ACK);
    assign ack_fall = fall_ev && (bit_cnt_ff == eep_pkg::BIT_ACK);
    assign frame_end = fall_ev && (bit_cnt_ff == eep_pkg::BIT_FRAME_END);
    assign in_prog = (state_ff == eep_pkg::ST_PROG);
    assign sel_match = (rx_byte[7:eep_pkg::SEL_ID_LSB] == TYPE_ID)
        && (rx_byte[eep_pkg::SEL_HI_BIT] == pins_s.strap_hi)
        && (rx_byte[eep_pkg::SEL_LO_BIT] == pins_s.strap_lo);
    assign tenth_stop = stop_ev && (state_ff == eep_pkg::ST_WDATA)
        && (bit_cnt_ff == eep_pkg::BIT_TENTH) && (mask_ff != '0);
    assign prog_done = in_prog
        && (prog_cnt_ff == eep_pkg::PROG_CNT_W'(PROG_CYCLES - 1));
    // Reads never look at the protection input.
    assign tx_start = frame_end && (((state_ff == eep_pkg::ST_SEL)
        && (shift_ff[eep_pkg::SEL_RW_BIT] == eep_pkg::SEL_READ))
        || (state_ff == eep_pkg::ST_RDATA));
    assign buf_wr = byte_done && (state_ff == eep_pkg::ST_WDATA) && !pins_s.wp;

    // Protocol state.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= eep_pkg::ST_IDLE;
        end else if (in_prog) begin
            if (prog_done) begin
                state_ff <= eep_pkg::ST_IDLE;
            end
        end else if (start_ev) begin
            state_ff <= eep_pkg::ST_SEL;
        end else if (stop_ev) begin
            state_ff <= tenth_stop ? eep_pkg::ST_PROG : eep_pkg::ST_IDLE;
        end else begin
            unique case (state_ff)
                eep_pkg::ST_SEL: begin
                    if (byte_done && !sel_match) begin
                        state_ff <= eep_pkg::ST_IDLE;
                    end else if (frame_end) begin
                        state_ff <= tx_start ? eep_pkg::ST_RDATA : eep_pkg::ST_ADDR;
                    end
                end
                eep_pkg::ST_ADDR: begin
                    if (frame_end) begin
                        state_ff <= eep_pkg::ST_WDATA;
                    end
                end
                eep_pkg::ST_RDATA: begin
                    if (ack_rise && link_bit_ff) begin
                        state_ff <= eep_pkg::ST_IDLE;
                    end
                end
                eep_pkg::ST_IDLE, eep_pkg::ST_WDATA: begin
                    state_ff <= state_ff;
                end
                default: begin
                    state_ff <= eep_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Position in the nine-clock frame.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt_ff <= 4'h0;
        end else if (in_prog || start_ev || stop_ev || frame_end) begin
            bit_cnt_ff <= 4'h0;
        end else if (rise_ev && (bit_cnt_ff < eep_pkg::BIT_FRAME_END)) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_ff <= 8'h00;
        end else if (rise_ev && (bit_cnt_ff < eep_pkg::BIT_ACK)) begin
            shift_ff <= rx_byte;
        end
    end

    // Acknowledge decision, made as the eighth bit arrives.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack_ff <= 1'h0;
        end else if (byte_done) begin
            unique case (state_ff)
                eep_pkg::ST_SEL: ack_ff <= sel_match;
                eep_pkg::ST_ADDR: ack_ff <= 1'h1;
                eep_pkg::ST_WDATA: ack_ff <= !pins_s.wp;
                default: ack_ff <= 1'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tx_ff <= 8'h00;
        end else if (tx_start) begin
            tx_ff <= mem_rdata;
        end
    end

    // Data pin drive changes only after a falling clock edge, or is released on start, stop or programming.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sda_oe_ff <= 1'h0;
        end else if (in_prog || start_ev || stop_ev) begin
            sda_oe_ff <= 1'h0;
        end else if (tx_start) begin
            sda_oe_ff <= ~mem_rdata[7];
        end else if (fall_ev && (state_ff == eep_pkg::ST_RDATA)) begin
            sda_oe_ff <= (bit_cnt_ff < eep_pkg::BIT_ACK)
                && ~tx_ff[3'(eep_pkg::BIT_MSB_IDX - bit_cnt_ff)];
        end else if (ack_fall) begin
            sda_oe_ff <= ack_ff;
        end else if (frame_end) begin
            sda_oe_ff <= 1'h0;
        end
    end

    // Address counter.
    assign next_after_last = {addr_ff[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W], last_off_ff}
        + 9'h001;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            addr_ff <= '0;
        end else if (prog_done) begin
            addr_ff <= next_after_last;
        end else if (in_prog) begin
            addr_ff <= addr_ff;
        end else if (byte_done && (state_ff == eep_pkg::ST_SEL) && sel_match) begin
            addr_ff[eep_pkg::ADDR_W-1] <= rx_byte[eep_pkg::SEL_MSB_BIT];
        end else if (byte_done && (state_ff == eep_pkg::ST_ADDR)) begin
            addr_ff[7:0] <= rx_byte;
        end else if (tx_start) begin
            addr_ff <= addr_ff + 9'h001;
        end
    end

    // Page offset and the record of which page bytes were written.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_off_ff <= '0;
            last_off_ff <= '0;
            mask_ff <= '0;
        end else if (prog_done) begin
            mask_ff <= '0;
        end else if (byte_done && (state_ff == eep_pkg::ST_ADDR)) begin
            wr_off_ff <= rx_byte[eep_pkg::PAGE_W-1:0];
            mask_ff <= '0;
        end else if (buf_wr) begin
            wr_off_ff <= wr_off_ff + 4'h1;
            last_off_ff <= wr_off_ff;
            mask_ff[wr_off_ff] <= 1'h1;
        end
    end

    // Programming timer; the page is copied in its first cycles.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prog_cnt_ff <= '0;
        end else if (in_prog) begin
            prog_cnt_ff <= prog_cnt_ff + eep_pkg::COPY_FIRST;
        end else begin
            prog_cnt_ff <= '0;
        end
    end

    assign copy_idx = eep_pkg::PAGE_W'(prog_cnt_ff - eep_pkg::COPY_FIRST);
    assign mem_wr = in_prog && (prog_cnt_ff >= eep_pkg::COPY_FIRST)
        && (prog_cnt_ff <= eep_pkg::COPY_LAST) && mask_ff[copy_idx];

    // Bytes wait in the page buffer so an early stop leaves the array untouched.
    eep_ram #(
        .W(eep_pkg::DATA_W),
        .D(eep_pkg::PAGE_DEPTH),
        .AW(eep_pkg::PAGE_W)
    ) u_page (
        .clk(sys_clk),
        .rst_n(rst_sync_n),
        .wr_en(buf_wr),
        .wr_addr(wr_off_ff),
        .wr_data(rx_byte),
        .rd_addr(prog_cnt_ff[eep_pkg::PAGE_W-1:0]),
        .rd_data(buf_rdata)
    );

    eep_ram #(
        .W(eep_pkg::DATA_W),
        .D(eep_pkg::MEM_DEPTH),
        .AW(eep_pkg::ADDR_W)
    ) u_array (
        .clk(sys_clk),
        .rst_n(rst_sync_n),
        .wr_en(mem_wr),
        .wr_addr({addr_ff[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W], copy_idx}),
        .wr_data(buf_rdata),
        .rd_addr(addr_ff),
        .rd_data(mem_rdata)
    );

    // Open drain: the pin is only ever pulled low.
    assign sda_out = 1'h0;
    assign sda_oe = sda_oe_ff;
    assign busy = in_prog;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    logic quiet;
    assign quiet = !start_ev && !stop_ev && !in_prog;

    prog_quiet_a: assert property (in_prog |-> !sda_oe)
        else $error("Data pin driven during programming.");
    start_sel_a: assert property (start_ev && !in_prog |=> state_ff == eep_pkg::ST_SEL)
        else $error("Start did not open a select byte.");
    stop_idle_a: assert property (stop_ev && !tenth_stop && !in_prog |=> state_ff == eep_pkg::ST_IDLE)
        else $error("Stop did not return to standby.");
    bit_capture_a: assert property (rise_ev && quiet && bit_cnt_ff < eep_pkg::BIT_ACK |=> shift_ff[0] == $past(link_bit_ff))
        else $error("Rising edge bit not captured.");
    ack_drive_a: assert property (ack_fall && quiet && ack_ff && state_ff != eep_pkg::ST_RDATA |=> sda_oe ##1 sda_oe)
        else $error("Acknowledge not driven.");
    sel_mismatch_a: assert property (byte_done && quiet && state_ff == eep_pkg::ST_SEL && !sel_match |=> state_ff == eep_pkg::ST_IDLE)
        else $error("Unmatched select did not deselect.");
    wp_nack_a: assert property (byte_done && quiet && state_ff == eep_pkg::ST_WDATA && pins_s.wp |=> !ack_ff && $stable(mask_ff))
        else $error("Protected data byte accepted.");
    addr_ack_a: assert property (byte_done && quiet && state_ff == eep_pkg::ST_ADDR |=> ack_ff)
        else $error("Address byte not acknowledged.");
    prog_start_a: assert property (tenth_stop && !in_prog |=> in_prog && prog_cnt_ff == '0)
        else $error("Tenth slot stop did not start programming.");
    prog_end_a: assert property (prog_done |=> state_ff == eep_pkg::ST_IDLE && addr_ff == $past(next_after_last))
        else $error("Counter not past last written byte.");
    read_nack_a: assert property (ack_rise && quiet && state_ff == eep_pkg::ST_RDATA && link_bit_ff |=> state_ff == eep_pkg::ST_IDLE)
        else $error("Read continued after no acknowledge.");
    read_inc_a: assert property (tx_start && quiet |=> addr_ff == $past(addr_ff) + 9'h001)
        else $error("Read did not advance the counter.");
    page_wrap_a: assert property (buf_wr && quiet |=> wr_off_ff == $past(wr_off_ff) + 4'h1)
        else $error("Page offset did not advance.");

    prog_run_c: cover property (tenth_stop ##[1:300] in_prog);
    prog_done_c: cover property (prog_done);
    seq_read_c: cover property (tx_start && state_ff == eep_pkg::ST_RDATA);
    read_stop_c: cover property (stop_ev && state_ff == eep_pkg::ST_IDLE);

endmodule // eep_i2c_slave

// File: eep_bus_master.sv
`timescale 1ns/1ps
module eep_bus_master #(
    parameter int Q = 1200
) (
    // Bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Serves as a repeated start too, since data is released while the clock is low.
    task automatic start();
        sda_low = 1'b0;
        #(Q);
        scl = 1'b1;
        #(Q);
        sda_low = 1'b1;
        #(Q);
        scl = 1'b0;
    endtask

    task automatic stop();
        #(Q/2);
        sda_low = 1'b1;
        #(Q/2);
        scl = 1'b1;
        #(Q);
        sda_low = 1'b0;
        #(Q);
    endtask

    // Data moves half way into the low phase, well after the device's hold time.
    task automatic bit_io(input logic b, output logic seen);
        #(Q/2);
        sda_low = !b;
        #(Q/2);
        scl = 1'b1;
        #(Q);
        seen = sda;
        scl = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(!ack, s);
    endtask
endmodule // eep_bus_master

// File: tb_eep_i2c_slave.sv
`timescale 1ns/1ps
module tb_eep_i2c_slave;
    // Value is arbitrary.
    localparam logic [3:0] TID = 4'h9;
    localparam int PROG = 1000;
    logic sys_clk;
    logic rst_n;
    logic scl_clk;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic sda_wire;
    logic strap_lo;
    logic strap_hi;
    logic wp;
    logic busy;
    int err_total;
    int samples_checked;

    // Pull-up wire: either party can only pull it low.
    assign sda_wire = !(sda_low || (sda_oe && !sda_out));

    eep_i2c_slave #(.PROG_CYCLES(PROG), .TYPE_ID(TID)) dut_u (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .scl_clk(scl_clk),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .strap_addr_low(strap_lo),
        .strap_addr_high(strap_hi),
        .write_protect_in(wp),
        .busy(busy)
    );

    eep_bus_master master_u (
        .scl(scl_clk),
        .sda_low(sda_low),
        .sda(sda_wire)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] sel(input logic a8, input logic rd);
        return {TID, strap_hi, strap_lo, a8, rd};
    endfunction

    task automatic set_addr(input logic [8:0] a);
        logic ack;
        master_u.start();
        master_u.wr_byte(sel(a[8], 1'b0), ack);
        chk("sel_ack", 8'(ack), 8'h01);
        master_u.wr_byte(a[7:0], ack);
        chk("addr_ack", 8'(ack), 8'h01);
    endtask

    // Writes, then polls with select bytes until the device answers again.
    task automatic wr_mem(input logic [8:0] a, input logic [7:0] d[$], input logic ok);
        logic ack;
        int n;
        set_addr(a);
        foreach (d[i]) begin
            master_u.wr_byte(d[i], ack);
            chk("data_ack", 8'(ack), 8'(ok));
        end
        master_u.stop();
        chk("busy_after_stop", 8'(busy), 8'(ok));
        for (n = 0; n < 20; n++) begin
            master_u.start();
            master_u.wr_byte(sel(1'b0, 1'b0), ack);
            master_u.stop();
            if (ack) begin
                break;
            end
        end
        if (n == 20) begin
            err_total++;
            test_done();
        end
        chk("poll_nack_busy", 8'(n > 0), 8'(ok));
        chk("busy_done", 8'(busy), 8'h00);
    endtask

    // Acknowledges every byte but the last, then stops.
    task automatic rd_seq(input logic a8, input logic [7:0] exp[$]);
        logic ack;
        logic [7:0] v;
        master_u.start();
        master_u.wr_byte(sel(a8, 1'b1), ack);
        chk("rd_sel_ack", 8'(ack), 8'h01);
        foreach (exp[i]) begin
            master_u.rd_byte(i < exp.size() - 1, v);
            chk("rd_data", v, exp[i]);
        end
        master_u.stop();
        chk("oe_after_nack", 8'(sda_oe), 8'h00);
    endtask

    task automatic sc_write_read();
        wr_mem(9'h000, '{8'h3C}, 1'b1);
        wr_mem(9'h1FF, '{8'hA5}, 1'b1);
        rd_seq(1'b0, '{8'h3C});
        set_addr(9'h1FF);
        rd_seq(1'b1, '{8'hA5, 8'h3C});
    endtask

    task automatic sc_page();
        wr_mem(9'h11E, '{8'h11, 8'h22, 8'h33}, 1'b1);
        set_addr(9'h11E);
        rd_seq(1'b1, '{8'h11, 8'h22});
        set_addr(9'h110);
        rd_seq(1'b1, '{8'h33});
    endtask

    task automatic sc_protect();
        @(posedge sys_clk);
        wp <= 1'b1;
        wr_mem(9'h000, '{8'h77, 8'h66}, 1'b0);
        set_addr(9'h000);
        rd_seq(1'b0, '{8'h3C});
        @(posedge sys_clk);
        wp <= 1'b0;
    endtask

    // A stop right after the address byte with no data, then select bytes with one field wrong.
    task automatic sc_refuse();
        logic ack;
        logic [7:0] masks[3] = '{8'h08, 8'h04, 8'h80};
        set_addr(9'h000);
        master_u.stop();
        chk("busy_no_data", 8'(busy), 8'h00);
        foreach (masks[i]) begin
            master_u.start();
            master_u.wr_byte(sel(1'b0, 1'b1) ^ masks[i], ack);
            chk("mismatch_nack", 8'(ack), 8'h00);
            master_u.stop();
        end
        @(posedge sys_clk);
        strap_lo <= 1'b1;
        set_addr(9'h000);
        rd_seq(1'b0, '{8'h3C});
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        wp = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk("busy_reset", 8'(busy), 8'h00);
        sc_write_read();
        sc_page();
        sc_protect();
        sc_refuse();
        test_done();
    end
endmodule // tb_eep_i2c_slave
